// ### oad_pkg.sv
// Constants and types shared by the operand address field decoder.
package oad_pkg;
    // ************************************************************
    // Register map and reset values.
    // ************************************************************
    localparam logic [7:0]  OAD_REQ_OFS     = 8'h00;
    localparam logic [7:0]  OAD_OPR_OFS     = 8'h04;
    localparam logic [7:0]  OAD_MEM_OFS     = 8'h08;
    localparam int          OAD_REQ_BYTES   = 3;
    localparam int          OAD_LEN_POS     = 16;
    localparam logic [23:0] OAD_REQ_RST     = 24'h00_0000;
    // ************************************************************
    // Field codes.
    // ************************************************************
    localparam logic [2:0]  OAD_R_BX        = 3'h3;
    localparam logic [2:0]  OAD_R_SP        = 3'h4;
    localparam logic [2:0]  OAD_R_BP        = 3'h5;
    localparam logic [2:0]  OAD_R_SI        = 3'h6;
    localparam logic [2:0]  OAD_R_DI        = 3'h7;
    localparam logic [1:0]  OAD_MOD_NODISP  = 2'h0;
    localparam logic [1:0]  OAD_MOD_BYTE    = 2'h1;
    localparam logic [1:0]  OAD_MOD_WIDE    = 2'h2;
    localparam logic [1:0]  OAD_MOD_REG     = 2'h3;
    localparam logic [2:0]  OAD_RM_SIB      = 3'h4;
    localparam logic [2:0]  OAD_RM_D32      = 3'h5;
    localparam logic [2:0]  OAD_RM_D16      = 3'h6;
    localparam logic [2:0]  OAD_IDX_NONE    = 3'h4;
    localparam logic [2:0]  OAD_DISP_NONE   = 3'h0;
    localparam logic [2:0]  OAD_DISP_BYTE   = 3'h1;
    localparam logic [2:0]  OAD_DISP_WORD   = 3'h2;
    localparam logic [2:0]  OAD_DISP_DWORD  = 3'h4;
    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [1:0] {
        OAD_BYTE_LO = 2'h0,
        OAD_BYTE_HI = 2'h1,
        OAD_WORD    = 2'h2,
        OAD_DWORD   = 2'h3
    } oad_rsize_type;
    typedef enum logic {
        OAD_BUS_IDLE = 1'h0,
        OAD_BUS_ACK  = 1'h1
    } oad_bus_type;
    typedef struct packed {
        logic          modrm_present;
        logic          addr32;
        logic          op32;
        logic          w_present;
        logic          w_bit;
        logic [2:0]    reg_field;
        logic [7:0]    sib;
        logic [7:0]    modrm;
    } oad_req_type;
    typedef struct packed {
        oad_rsize_type size;
        logic [2:0]    num;
    } oad_opr_type;
    typedef struct packed {
        logic          ea_undef;
        logic          sib_follows;
        logic [2:0]    disp_len;
        logic          stack_seg;
        logic [1:0]    scale_shift;
        logic          index_valid;
        logic [2:0]    index_reg;
        logic          base_valid;
        logic [2:0]    base_reg;
        logic          rm_is_reg;
        logic          modrm_used;
    } oad_mem_type;
endpackage

// ### oad_dec_if.sv
// Interface joining the decoder top level to its two decode stages.
`timescale 1ns/1ns
interface oad_dec_if;
    oad_pkg::oad_req_type       req;
    logic [1:0][2:0]            src;
    oad_pkg::oad_opr_type [1:0] opr;
    oad_pkg::oad_mem_type       mem;
    modport top (output req, output src, input opr, input mem);
    modport sel (input req, input src, output opr);
    modport agu (input req, output mem);
endinterface

// ### oad_reg_sel.sv
// Register field selectors for the reg field and the register form of r/m.
`timescale 1ns/1ns
module oad_reg_sel (
    oad_dec_if.sel dec
);
    function automatic oad_pkg::oad_opr_type pick(
        input logic [2:0]           code,
        input oad_pkg::oad_req_type r
    );
        oad_pkg::oad_opr_type o;
        if (r.w_present && !r.w_bit) begin
            o.size = code[2] ? oad_pkg::OAD_BYTE_HI : oad_pkg::OAD_BYTE_LO;
            o.num  = {1'h0, code[1:0]};
        end else begin
            o.size = r.op32 ? oad_pkg::OAD_DWORD : oad_pkg::OAD_WORD;
            o.num  = code;
        end
        return o;
    endfunction

    // ************************************************************
    // One selector per field.
    // ************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_sel
        assign dec.opr[i] = pick(dec.src[i], dec.req); // [RULE_01] [RULE_02] [RULE_03] [RULE_16]
    end
endmodule

// ### oad_mem_dec.sv
// Memory addressing recipe decode from the mod r/m and s-i-b bytes.
`timescale 1ns/1ns
module oad_mem_dec (
    oad_dec_if.agu dec
);
    logic [1:0] md;
    logic [2:0] rm;
    logic [1:0] ss;
    logic [2:0] sx;
    logic [2:0] sb;
    logic [2:0] wide_len;

    assign md = dec.req.modrm[7:6];
    assign rm = dec.req.modrm[2:0];
    assign ss = dec.req.sib[7:6];
    assign sx = dec.req.sib[5:3];
    assign sb = dec.req.sib[2:0];
    assign wide_len = dec.req.addr32 ? oad_pkg::OAD_DISP_DWORD : oad_pkg::OAD_DISP_WORD;

    always_comb begin
        oad_pkg::oad_mem_type m;
        m = '0;
        if (dec.req.modrm_present) begin // [RULE_05]
            m.modrm_used = 1'h1;
            if (md != oad_pkg::OAD_MOD_REG) begin
                m.disp_len = (md == oad_pkg::OAD_MOD_BYTE) ? oad_pkg::OAD_DISP_BYTE :
                             (md == oad_pkg::OAD_MOD_WIDE) ? wide_len :
                             oad_pkg::OAD_DISP_NONE; // [RULE_07] [RULE_10] [RULE_13]
                m.base_valid = 1'h1;
            end
            if (md == oad_pkg::OAD_MOD_REG) begin
                m.rm_is_reg = 1'h1; // [RULE_04] [RULE_11]
            end else if (!dec.req.addr32) begin
                m.base_reg    = rm[1] ? oad_pkg::OAD_R_BP : oad_pkg::OAD_R_BX; // [RULE_06]
                m.index_valid = ~rm[2];
                m.index_reg   = rm[2] ? 3'h0 : (rm[0] ? oad_pkg::OAD_R_DI : oad_pkg::OAD_R_SI);
                m.stack_seg   = ~rm[2] & rm[1];
                if (rm[2]) begin
                    unique case (rm[1:0])
                        2'h0: m.base_reg = oad_pkg::OAD_R_SI;
                        2'h1: m.base_reg = oad_pkg::OAD_R_DI;
                        2'h2: begin
                            m.base_reg  = oad_pkg::OAD_R_BP; // [RULE_07]
                            m.stack_seg = 1'h1;
                            if (md == oad_pkg::OAD_MOD_NODISP) begin
                                m.base_valid = 1'h0; // [RULE_06]
                                m.base_reg   = 3'h0;
                                m.stack_seg  = 1'h0;
                                m.disp_len   = oad_pkg::OAD_DISP_WORD;
                            end
                        end
                        2'h3: m.base_reg = oad_pkg::OAD_R_BX;
                    endcase
                end
            end else if (rm == oad_pkg::OAD_RM_SIB) begin
                m.sib_follows = 1'h1; // [RULE_08]
                m.base_reg    = sb; // [RULE_12]
                m.index_valid = (sx != oad_pkg::OAD_IDX_NONE); // [RULE_15]
                m.index_reg   = m.index_valid ? sx : 3'h0;
                m.scale_shift = ss; // [RULE_14]
                m.ea_undef    = !m.index_valid && (ss != 2'h0); // [RULE_15]
                m.stack_seg   = (sb == oad_pkg::OAD_R_SP) ||
                                (sb == oad_pkg::OAD_R_BP && md != oad_pkg::OAD_MOD_NODISP); // [RULE_13]
            end else begin
                m.base_reg  = rm; // [RULE_09]
                m.stack_seg = (rm == oad_pkg::OAD_R_BP) && (md != oad_pkg::OAD_MOD_NODISP); // [RULE_10]
                if (md == oad_pkg::OAD_MOD_NODISP && rm == oad_pkg::OAD_RM_D32) begin
                    m.base_valid = 1'h0; // [RULE_09]
                    m.base_reg   = 3'h0;
                    m.disp_len   = oad_pkg::OAD_DISP_DWORD;
                end
            end
        end
        dec.mem = m;
    end
endmodule

// ### oad_top.sv
// Operand address field decoder top level with a Wishbone register port.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Contract
// RULE_01: Without width bit, field picks word or dword.
// RULE_02: Width zero picks low then high bytes.
// RULE_03: Width one picks full register by size.
// RULE_04: Mod and r/m decode together; eleven means register.
// RULE_05: No addressing byte means nothing consumed.
// RULE_06: Sixteen-bit mod zero forms and direct word.
// RULE_07: Sixteen-bit mod one/two add displacement.
// RULE_08: Thirty-two-bit r/m four requests s-i-b byte.
// RULE_09: Mod zero register indirect; code five direct.
// RULE_10: Mod one/two add displacement; frame pointer stack.
// RULE_11: Register form r/m follows width and size.
// RULE_12: S-i-b base plus scaled index addressing.
// RULE_13: S-i-b displacement and stack segment choice.
// RULE_14: Scale field multiplies index by 1,2,4,8.
// RULE_15: Index four means none; scale must be zero.
// RULE_16: Width bit chooses byte or full operand.
// RULE_17: Report displacement length and s-i-b request.
module oad_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_we,
    input  wire logic [ADDR_W-1:0] wb_adr,
    input  wire logic [3:0]        wb_sel,
    input  wire logic [31:0]       wb_wdata,
    output logic                   wb_ack,
    output logic      [31:0]       wb_rdata,
    output logic                   dec_modrm_used,
    output logic                   dec_sib_follows,
    output logic      [2:0]        dec_disp_len,
    output logic      [2:0]        dec_spec_len
);
    // ************************************************************
    // Elaboration checks.
    // ************************************************************
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_width
        $error("ADDR_W must lie between 8 and 32.");
    end

    localparam logic [ADDR_W-1:0] REQ_A = ADDR_W'(oad_pkg::OAD_REQ_OFS);
    localparam logic [ADDR_W-1:0] OPR_A = ADDR_W'(oad_pkg::OAD_OPR_OFS);
    localparam logic [ADDR_W-1:0] MEM_A = ADDR_W'(oad_pkg::OAD_MEM_OFS);

    oad_pkg::oad_bus_type       bus_ff;
    oad_pkg::oad_bus_type       nxt_bus;
    logic                       take;
    logic                       hit_req;
    logic                       hit_opr;
    logic                       hit_mem;
    logic [23:0]                req_bits_ff;
    oad_pkg::oad_req_type       req;
    oad_pkg::oad_opr_type [1:0] opr_ff;
    oad_pkg::oad_mem_type       mem_ff;
    logic [2:0]                 len_ff;
    logic [2:0]                 nxt_len;
    logic [31:0]                rdata_ff;
    logic [31:0]                nxt_rdata;

    oad_dec_if dec_bus ();

    // ************************************************************
    // Bus handshake.
    // ************************************************************
    assign take    = wb_cyc && wb_stb && (bus_ff == oad_pkg::OAD_BUS_IDLE);
    assign hit_req = wb_adr[ADDR_W-1:2] == REQ_A[ADDR_W-1:2];
    assign hit_opr = wb_adr[ADDR_W-1:2] == OPR_A[ADDR_W-1:2];
    assign hit_mem = wb_adr[ADDR_W-1:2] == MEM_A[ADDR_W-1:2];

    always_comb begin
        unique case (bus_ff)
            oad_pkg::OAD_BUS_IDLE: begin
                nxt_bus = take ? oad_pkg::OAD_BUS_ACK : oad_pkg::OAD_BUS_IDLE;
            end
            oad_pkg::OAD_BUS_ACK: begin
                nxt_bus = oad_pkg::OAD_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_ff <= oad_pkg::OAD_BUS_IDLE;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    assign wb_ack = (bus_ff == oad_pkg::OAD_BUS_ACK);

    // ************************************************************
    // Request register.
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_bits_ff <= oad_pkg::OAD_REQ_RST;
        end else if (take && wb_we && hit_req) begin
            for (int b = 0; b < oad_pkg::OAD_REQ_BYTES; b++) begin
                if (wb_sel[b]) begin
                    req_bits_ff[b*8 +: 8] <= wb_wdata[b*8 +: 8];
                end
            end
        end
    end

    assign req = oad_pkg::oad_req_type'(req_bits_ff);

    // ************************************************************
    // Decode stages.
    // ************************************************************
    assign dec_bus.req    = req;
    assign dec_bus.src[0] = req.reg_field;
    assign dec_bus.src[1] = req.modrm[2:0];

    oad_reg_sel u_reg_sel (
        .dec (dec_bus.sel)
    );

    oad_mem_dec u_mem_dec (
        .dec (dec_bus.agu)
    );

    // ************************************************************
    // Result registers.
    // ************************************************************
    assign nxt_len = 3'(dec_bus.mem.modrm_used) + 3'(dec_bus.mem.sib_follows)
                   + dec_bus.mem.disp_len; // [RULE_17]

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            opr_ff <= '0;
            mem_ff <= '0;
            len_ff <= 3'h0;
        end else begin
            opr_ff <= dec_bus.opr;
            mem_ff <= dec_bus.mem;
            len_ff <= nxt_len;
        end
    end

    assign dec_modrm_used  = mem_ff.modrm_used; // [RULE_05]
    assign dec_sib_follows = mem_ff.sib_follows; // [RULE_17]
    assign dec_disp_len    = mem_ff.disp_len; // [RULE_17]
    assign dec_spec_len    = len_ff;

    // ************************************************************
    // Read back.
    // ************************************************************
    always_comb begin
        if (hit_req) begin
            nxt_rdata = 32'(req_bits_ff);
        end else if (hit_opr) begin
            nxt_rdata = 32'(opr_ff) | (32'(len_ff) << oad_pkg::OAD_LEN_POS);
        end else if (hit_mem) begin
            nxt_rdata = 32'(mem_ff);
        end else begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (take && !wb_we) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign wb_rdata = rdata_ff;

    // ************************************************************
    // Checks.
    // ************************************************************
    logic [1:0] req_mod;
    logic [2:0] req_rm;
    logic       req_sib_form;

    assign req_mod      = req.modrm[7:6];
    assign req_rm       = req.modrm[2:0];
    assign req_sib_form = req.modrm_present && req.addr32 && req_mod != oad_pkg::OAD_MOD_REG
                          && req_rm == oad_pkg::OAD_RM_SIB;

    chk_byte_reg_sel: assert property ( // [RULE_02] [RULE_16]
        @(posedge sys_clk) disable iff (!reset_n)
        req.w_present && !req.w_bit
        |=> opr_ff[0].size == ($past(req.reg_field[2]) ? oad_pkg::OAD_BYTE_HI
                                                         : oad_pkg::OAD_BYTE_LO)
            && opr_ff[0].num == {1'h0, $past(req.reg_field[1:0])}
    ) else $error("Byte register select is wrong.");

    chk_full_reg_sel: assert property ( // [RULE_01] [RULE_03]
        @(posedge sys_clk) disable iff (!reset_n)
        !req.w_present || req.w_bit
        |=> opr_ff[0].size == ($past(req.op32) ? oad_pkg::OAD_DWORD : oad_pkg::OAD_WORD)
            && opr_ff[0].num == $past(req.reg_field)
    ) else $error("Full register select is wrong.");

    chk_rm_reg_form: assert property ( // [RULE_04] [RULE_11]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && req_mod == oad_pkg::OAD_MOD_REG
        |=> mem_ff.rm_is_reg && !mem_ff.base_valid && mem_ff.disp_len == 3'h0
            && opr_ff[1].num[1:0] == $past(req_rm[1:0])
    ) else $error("Register form of r/m is wrong.");

    chk_no_modrm: assert property ( // [RULE_05]
        @(posedge sys_clk) disable iff (!reset_n)
        !req.modrm_present
        |=> !dec_modrm_used && !dec_sib_follows && dec_spec_len == 3'h0
    ) else $error("Absent addressing byte was consumed.");

    chk_direct_word: assert property ( // [RULE_06]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && !req.addr32 && req_mod == oad_pkg::OAD_MOD_NODISP
        && req_rm == oad_pkg::OAD_RM_D16
        |=> !mem_ff.base_valid && dec_disp_len == oad_pkg::OAD_DISP_WORD
    ) else $error("Direct word form is wrong.");

    chk_frame_word: assert property ( // [RULE_07]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && !req.addr32 && req_rm == oad_pkg::OAD_RM_D16
        && (req_mod == oad_pkg::OAD_MOD_BYTE || req_mod == oad_pkg::OAD_MOD_WIDE)
        |=> mem_ff.base_reg == oad_pkg::OAD_R_BP && mem_ff.stack_seg
            && dec_disp_len == ($past(req_mod[1]) ? oad_pkg::OAD_DISP_WORD
                                                  : oad_pkg::OAD_DISP_BYTE)
    ) else $error("Frame pointer word form is wrong.");

    chk_sib_request: assert property ( // [RULE_08]
        @(posedge sys_clk) disable iff (!reset_n)
        req_sib_form
        |=> dec_sib_follows && mem_ff.base_reg == $past(req.sib[2:0])
    ) else $error("S-i-b request is wrong.");

    chk_direct_dword: assert property ( // [RULE_09]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && req.addr32 && req_mod == oad_pkg::OAD_MOD_NODISP
        && req_rm == oad_pkg::OAD_RM_D32
        |=> !mem_ff.base_valid && !mem_ff.stack_seg
            && dec_disp_len == oad_pkg::OAD_DISP_DWORD && dec_spec_len == 3'h5
    ) else $error("Direct doubleword form is wrong.");

    chk_frame_dword: assert property ( // [RULE_10]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && req.addr32 && req_mod == oad_pkg::OAD_MOD_WIDE
        && req_rm == oad_pkg::OAD_RM_D32
        |=> mem_ff.base_reg == oad_pkg::OAD_R_BP && mem_ff.stack_seg
            && dec_disp_len == oad_pkg::OAD_DISP_DWORD
    ) else $error("Frame pointer doubleword form is wrong.");

    chk_sib_segment: assert property ( // [RULE_12] [RULE_13]
        @(posedge sys_clk) disable iff (!reset_n)
        req_sib_form
        |=> mem_ff.stack_seg == ($past(req.sib[2:0]) == oad_pkg::OAD_R_SP
                                 || ($past(req.sib[2:0]) == oad_pkg::OAD_R_BP
                                     && $past(req_mod) != oad_pkg::OAD_MOD_NODISP))
    ) else $error("S-i-b segment choice is wrong.");

    chk_sib_scale: assert property ( // [RULE_14]
        @(posedge sys_clk) disable iff (!reset_n)
        req_sib_form
        |=> mem_ff.scale_shift == $past(req.sib[7:6])
    ) else $error("Scale factor is wrong.");

    chk_no_index: assert property ( // [RULE_15]
        @(posedge sys_clk) disable iff (!reset_n)
        req_sib_form && req.sib[5:3] == oad_pkg::OAD_IDX_NONE
        |=> !mem_ff.index_valid && mem_ff.ea_undef == ($past(req.sib[7:6]) != 2'h0)
    ) else $error("Missing index handling is wrong.");

    chk_spec_length: assert property ( // [RULE_17]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && req.addr32 && req_mod == oad_pkg::OAD_MOD_WIDE
        |=> dec_spec_len == ($past(req_sib_form) ? 3'h6 : 3'h5)
    ) else $error("Specifier length is wrong.");

    chk_pair_index: assert property ( // [RULE_06]
        @(posedge sys_clk) disable iff (!reset_n)
        req.modrm_present && !req.addr32 && req_mod != oad_pkg::OAD_MOD_REG && !req_rm[2]
        |=> mem_ff.index_valid && mem_ff.stack_seg == $past(req_rm[1])
            && mem_ff.base_reg == ($past(req_rm[1]) ? oad_pkg::OAD_R_BP : oad_pkg::OAD_R_BX)
    ) else $error("Two register word form is wrong.");

    chk_bus_answer: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        take |=> wb_ack ##1 !wb_ack
    ) else $error("Bus acknowledge is not one cycle.");

    chk_write_lands: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        take && wb_we && hit_req && wb_sel == 4'hf
        |=> req_bits_ff == $past(wb_wdata[23:0])
    ) else $error("Request write did not land.");

    cov_sib_dword: cover property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_sib_form && req_mod == oad_pkg::OAD_MOD_WIDE
    );

    cov_direct_word: cover property (
        @(posedge sys_clk) disable iff (!reset_n)
        dec_spec_len == 3'h3 && !mem_ff.base_valid
    );

    cov_high_byte: cover property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_ff.rm_is_reg && opr_ff[1].size == oad_pkg::OAD_BYTE_HI
    );

    cov_undef_scale: cover property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_ff.ea_undef
    );

    cov_bus_read: cover property (
        @(posedge sys_clk) disable iff (!reset_n)
        take && !wb_we ##1 wb_ack
    );
endmodule

// ### oad_fetch_model.sv
// Fetch-side model that hands decode requests to the block over Wishbone.
`timescale 1ns/1ns
module oad_fetch_model (
    input  wire logic        sys_clk,
    input  wire logic        wb_ack,
    input  wire logic [31:0] wb_rdata,
    output logic             wb_cyc,
    output logic             wb_stb,
    output logic             wb_we,
    output logic [7:0]       wb_adr,
    output logic [3:0]       wb_sel,
    output logic [31:0]      wb_wdata
);
    // ************************************************************
    // Classic single bus cycle.
    // ************************************************************
    initial begin
        wb_cyc   = 1'b0;
        wb_stb   = 1'b0;
        wb_we    = 1'b0;
        wb_adr   = 8'h00;
        wb_sel   = 4'h0;
        wb_wdata = 32'h0;
    end
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= sel;
        wb_wdata <= wd;
        @(posedge sys_clk);
        while (wb_ack !== 1'b1)
            @(posedge sys_clk);
        rd = wb_rdata;
        wb_cyc   <= 1'b0;
        wb_stb   <= 1'b0;
        wb_adr   <= ~adr;
        wb_wdata <= ~wd;
    endtask
endmodule

// ### oad_top_bench.sv
// Self-checking bench for the operand address field decoder.
`timescale 1ns/1ns
module oad_top_bench;
    // ************************************************************
    // Harness, checks and scenarios.
    // ************************************************************
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        wb_cyc, wb_stb, wb_we, wb_ack, dec_modrm_used, dec_sib_follows;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdata, wb_rdata, rdv;
    logic [2:0]  dec_disp_len, dec_spec_len;
    int          n_mismatch = 0;
    int          num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    oad_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
        .wb_ack(wb_ack), .wb_rdata(wb_rdata), .dec_modrm_used(dec_modrm_used),
        .dec_sib_follows(dec_sib_follows), .dec_disp_len(dec_disp_len),
        .dec_spec_len(dec_spec_len));
    oad_fetch_model FM (.sys_clk(sys_clk), .wb_ack(wb_ack), .wb_rdata(wb_rdata),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_wdata(wb_wdata));
    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] ex);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    function automatic logic [31:0] mw(input logic [2:0] b, input logic bv,
        input logic [2:0] i, input logic iv, input logic [1:0] sc, input logic st,
        input logic [2:0] dl, input logic sf, input logic un);
        return {14'h0, un, sf, dl, st, sc, iv, i, bv, b, 2'b01};
    endfunction
    function automatic logic [4:0] ex_reg(input logic [2:0] c, input logic wp,
        input logic w, input logic o);
        if (wp && !w)
            return {c[2] ? oad_pkg::OAD_BYTE_HI : oad_pkg::OAD_BYTE_LO, 1'b0, c[1:0]};
        return {o ? oad_pkg::OAD_DWORD : oad_pkg::OAD_WORD, c};
    endfunction
    task automatic wr(input logic [23:0] rq);
        FM.bus(1'b1, 8'h00, 4'hf, {8'h00, rq}, rdv);
    endtask
    task automatic mem_case(input logic [23:0] rq, input logic [31:0] ex);
        wr(rq);
        FM.bus(1'b0, 8'h08, 4'hf, 32'h0, rdv);
        cmp32(rdv, ex);
        cmp32(32'(dec_disp_len), 32'(ex[15:13]));
        cmp32(32'(dec_sib_follows), 32'(ex[16]));
        cmp32(32'(dec_spec_len), 32'(ex[15:13]) + ex[0] + ex[16]);
    endtask
    task automatic t_start;
        FM.bus(1'b0, 8'h00, 4'hf, 32'h0, rdv);
        cmp32(rdv, 32'h0);
        FM.bus(1'b1, 8'h08, 4'hf, 32'hffff_ffff, rdv);
        FM.bus(1'b0, 8'h08, 4'hf, 32'h0, rdv);
        cmp32(rdv, 32'h0);
        FM.bus(1'b0, 8'h0c, 4'hf, 32'h0, rdv);
        cmp32(rdv, 32'h0);
        FM.bus(1'b1, 8'h00, 4'hf, 32'hffff_ffff, rdv);
        FM.bus(1'b1, 8'h00, 4'h1, 32'h0, rdv);
        FM.bus(1'b0, 8'h00, 4'hf, 32'h0, rdv);
        cmp32(rdv, 32'h00ff_ff00);
        mem_case(24'h40_0004, 32'h0);
    endtask
    task automatic t_regf;
        for (int k = 0; k < 64; k++) begin
            if (!k[5] && k[4])
                continue;
            wr({1'b1, 1'b0, k[3], k[5], k[4], k[2:0], 8'h00, 5'h18, ~k[2:0]});
            FM.bus(1'b0, 8'h04, 4'hf, 32'h0, rdv);
            cmp32(32'(rdv[4:0]), 32'(ex_reg(k[2:0], k[5], k[4], k[3])));
            if (k[5])
                cmp32(32'(rdv[9:5]), 32'(ex_reg(~k[2:0], 1'b1, k[4], k[3])));
            cmp32(32'(rdv[18:16]), 32'h1);
            cmp32(32'({dec_modrm_used, dec_sib_follows, dec_disp_len}), 32'h10);
        end
    endtask
    task automatic t_mem(input logic a32);
        logic [2:0] b, i, dl, rm;
        logic [1:0] md;
        logic       bv, iv;
        for (int k = 0; k < 24; k++) begin
            md = k[4:3];
            rm = k[2:0];
            if (a32 && rm == 3'h4)
                continue;
            bv = !(md == 2'h0 && rm == (a32 ? 3'h5 : 3'h6));
            b = a32 ? rm : rm[2] ? (rm[1] ? (rm[0] ? 3'h3 : 3'h5) : {2'b11, rm[0]})
                               : (rm[1] ? 3'h5 : 3'h3);
            if (!bv)
                b = 3'h0;
            iv = !a32 && !rm[2];
            i = iv ? {2'b11, rm[0]} : 3'h0;
            dl = md == 2'h1 ? 3'h1 : (md == 2'h2 || !bv) ? (a32 ? 3'h4 : 3'h2) : 3'h0;
            mem_case({1'b1, a32, 6'h00, 8'h00, md, 3'h0, rm},
                mw(b, bv, i, iv, 2'h0, bv && b == 3'h5, dl, 1'b0, 1'b0));
        end
    endtask
    task automatic t_sib;
        logic [2:0] x, b;
        logic [1:0] md;
        for (int k = 0; k < 24; k++) begin
            md = k[4:3];
            b = k[2:0];
            x = b ^ 3'h7;
            mem_case({8'hc0, b[1:0], x, b, md, 6'h04}, mw(b, 1'b1, x == 3'h4 ? 3'h0 : x,
                x != 3'h4, b[1:0], b == 3'h4 || (b == 3'h5 && md != 2'h0),
                md == 2'h0 ? 3'h0 : md == 2'h1 ? 3'h1 : 3'h4, 1'b1,
                x == 3'h4 && b[1:0] != 2'h0));
        end
    endtask
    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_start;
        t_regf;
        t_mem(1'b0);
        t_mem(1'b1);
        t_sib;
        end_sim;
    end
endmodule
